// ==== design/dpm_pkg.sv ====
// constants, modes and carriers of the dual-port memory block
// Functional notes
// - input clear empties input registers at once; output changes only later
// - output clear zeroes the output register, seen on the output directly
// - single-port mode: one port, read or write, never both together
// - simple dual-port: write port and read port act in one cycle
// - simple dual-port allows different read and write widths
// - true dual-port: each port reads or writes on its own clock
// - true dual-port allows different widths on the two sides
// - shift mode: write on falling edge, read on rising edge
// - ROM contents are loaded at configuration time
// - FIFO with one or two clocks; no read and write when empty
// - independent clocking: each port's registers run on its own clock
// - input/output clocking: one clock for inputs, one for outputs
// - read/write clocking: write clock for write side, read clock for read side
// - single clocking: one clock with enable, no register clears
// - only documented memory mode and clock mode pairings are allowed
// - sixteen direct links in and out on each side
// - same-port read during write returns the new data, the old data in shift mode
// - mixed-port read during write returns the old data
// - input registers always present; output registers bypassable
// - bytes not enabled keep their stored value (FIFO writes store both bytes whatever the enables)
package dpm_pkg;
   localparam int          DPM_AW        = 8;
   localparam int          DPM_WORDS     = 256;
   localparam int          DPM_DL_W      = 16;
   localparam logic [7:0]  DPM_CTRL_OFS  = 8'h00;
   localparam logic [7:0]  DPM_STAT_OFS  = 8'h04;
   localparam logic [7:0]  DPM_IADDR_OFS = 8'h08;
   localparam logic [7:0]  DPM_IDATA_OFS = 8'h0c;
   localparam int          CTRL_MODE_POS = 0;
   localparam int          CTRL_CLK_POS  = 3;
   localparam int          CTRL_OREG_POS = 5;
   localparam int          CTRL_NAR_POS  = 7;
   localparam int          CTRL_EN_POS   = 9;
   localparam int          CTRL_CE_POS   = 10;
   localparam logic [31:0] DPM_CTRL_MASK = 32'h0000_07ff;
   localparam logic [31:0] DPM_CTRL_RST  = 32'h0000_0408;
   localparam int          ST_CFGERR_POS = 0;
   localparam int          ST_EMPTY_POS  = 1;
   localparam int          ST_FULL_POS   = 2;
   localparam int          ST_PROTO_POS  = 3;
   localparam int          ST_ROMWR_POS  = 4;
   localparam int          ST_CNT_POS    = 16;
   localparam logic [1:0]  AXI_OKAY      = 2'b00;
   localparam logic [1:0]  AXI_SLVERR    = 2'b10;

   typedef enum logic [2:0] {DPM_SP, DPM_SDP, DPM_TDP, DPM_SHIFT, DPM_ROM, DPM_FIFO}
      dpm_mode_type;
   typedef enum logic [1:0] {DPM_CK_INDEP, DPM_CK_IO, DPM_CK_RW, DPM_CK_SINGLE}
      dpm_clk_type;

   typedef struct packed {
      logic [8:0] addr;
      logic [1:0] be;
      logic       we;
      logic       re;
      logic       clr_in;
      logic       clr_out;
   } dpm_port_type;
endpackage

// ==== design/dpm_top.sv ====
// dual-port memory block with AXI4-Lite configuration and status
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module dpm_top (
   input  logic                   aclk,
   input  logic                   aresetn,
   input  logic [7:0]             s_axi_awaddr,
   input  logic                   s_axi_awvalid,
   output logic                   s_axi_awready,
   input  logic [31:0]            s_axi_wdata,
   input  logic [3:0]             s_axi_wstrb,
   input  logic                   s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  logic                   s_axi_bready,
   input  logic [7:0]             s_axi_araddr,
   input  logic                   s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  logic                   s_axi_rready,
   input  logic [1:0]             clk_stb,
   input  dpm_pkg::dpm_port_type  port_a,
   input  dpm_pkg::dpm_port_type  port_b,
   input  logic [15:0]            dl_left_in,
   input  logic [15:0]            dl_right_in,
   output logic [15:0]            dl_left_out,
   output logic [15:0]            dl_right_out
);
   import dpm_pkg::*;

   logic [15:0]  mem [DPM_WORDS];
   logic [31:0]  ctrl_r;
   logic [7:0]   iaddr_r;
   dpm_mode_type mode;
   dpm_clk_type  ckm;
   logic         cfg_ok;
   logic         run;
   logic         clr_ok;
   logic [3:0]   stb;
   dpm_port_type pin [2];
   logic [15:0]  din [2];
   dpm_port_type in_r [2];
   logic [15:0]  dat_r [2];
   logic [1:0]   go_r;
   logic [1:0]   nar;
   logic [7:0]   wa [2];
   logic [1:0]   ln [2];
   logic [15:0]  old [2];
   logic [15:0]  wd [2];
   logic [15:0]  rv [2];
   logic [1:0]   req_w;
   logic [1:0]   req_r;
   logic [1:0]   wr;
   logic [1:0]   rd;
   logic [15:0]  rd_r [2];
   logic [15:0]  q_r [2];
   logic [7:0]   wptr_r;
   logic [7:0]   rptr_r;
   logic [8:0]   cnt_r;
   logic         empty;
   logic         full;
   logic         fwr;
   logic         frd;
   logic         proto_ev;
   logic         romwr_ev;
   logic         proto_r;
   logic         romwr_r;
   logic         awready_r;
   logic         wready_r;
   logic         bvalid_r;
   logic [1:0]   bresp_r;
   logic         aw_have_r;
   logic         w_have_r;
   logic [7:0]   awaddr_r;
   logic [31:0]  wdata_r;
   logic [3:0]   wstrb_r;
   logic         wdo;
   logic         init_we;
   logic         st_clr;
   logic         arready_r;
   logic         rvalid_r;
   logic [31:0]  rdata_r;
   logic [1:0]   rresp_r;
   logic [31:0]  stat;

   // legal pairings of memory mode and clock mode
   function automatic logic legal(dpm_mode_type m, dpm_clk_type c);
      case (m)
         DPM_SP, DPM_ROM, DPM_SHIFT:
            legal = (c == DPM_CK_IO) || (c == DPM_CK_SINGLE);
         DPM_SDP, DPM_FIFO:
            legal = (c != DPM_CK_INDEP);
         DPM_TDP:
            legal = (c != DPM_CK_RW);
         default:
            legal = 1'b0;
      endcase
   endfunction

   // word index of a port address at its width
   function automatic logic [7:0] word(logic n, logic [8:0] a);
      word = n ? a[8:1] : a[7:0];
   endfunction

   // byte lanes touched by a write
   function automatic logic [1:0] lanes(logic n, logic [8:0] a, logic [1:0] be);
      if (n)
         lanes = be[0] ? (a[0] ? 2'b10 : 2'b01) : 2'b00;
      else
         lanes = be;
   endfunction

   // keep old bytes where the lane is off
   function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n, logic [1:0] l);
      merge = {l[1] ? n[15:8] : o[15:8], l[0] ? n[7:0] : o[7:0]};
   endfunction

   // register address hit
   function automatic logic hit(logic [7:0] a);
      hit = (a == DPM_CTRL_OFS) || (a == DPM_STAT_OFS) ||
            (a == DPM_IADDR_OFS) || (a == DPM_IDATA_OFS);
   endfunction

   // configuration decode
   assign mode   = dpm_mode_type'(ctrl_r[CTRL_MODE_POS +: 3]);
   assign ckm    = dpm_clk_type'(ctrl_r[CTRL_CLK_POS +: 2]);
   assign cfg_ok = legal(mode, ckm);
   assign run    = ctrl_r[CTRL_EN_POS] && cfg_ok;
   assign clr_ok = (ckm != DPM_CK_SINGLE);
   assign pin[0] = port_a;
   assign pin[1] = port_b;
   assign din[0] = dl_left_in;
   assign din[1] = dl_right_in;

   // clock strobes per group: out_b, out_a, in_b, in_a
   always_comb
   begin
      case (ckm)
         DPM_CK_IO:
            stb = {clk_stb[1], clk_stb[1], clk_stb[0], clk_stb[0]};
         DPM_CK_RW:
            stb = {clk_stb[1], clk_stb[0], clk_stb[1], clk_stb[0]};
         DPM_CK_SINGLE:
            stb = {4{clk_stb[0] & ctrl_r[CTRL_CE_POS]}};
         default:
            stb = {clk_stb[1], clk_stb[0], clk_stb[1], clk_stb[0]};
      endcase
   end

   // input registers: always in the path, cleared by their own clear except in single clocking
   always_ff @(posedge aclk)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (!aresetn || (clr_ok && pin[p].clr_in))
         begin
            in_r[p]  <= '0;
            dat_r[p] <= '0;
            go_r[p]  <= 1'b0;
         end
         else
         begin
            go_r[p] <= stb[p];
            if (stb[p])
            begin
               in_r[p]  <= pin[p];
               dat_r[p] <= din[p];
            end
         end
      end
   end

   // access decode per mode
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         req_w[p] = run && go_r[p] && in_r[p].we;
         req_r[p] = run && go_r[p] && in_r[p].re;
         nar[p]   = ctrl_r[CTRL_NAR_POS + p] && (mode != DPM_FIFO);
         wa[p]    = word(nar[p], in_r[p].addr);
         ln[p]    = lanes(nar[p], in_r[p].addr, in_r[p].be);
         wd[p]    = nar[p] ? {dat_r[p][7:0], dat_r[p][7:0]} : dat_r[p];
      end
      wr       = 2'b00;
      rd       = 2'b00;
      fwr      = 1'b0;
      frd      = 1'b0;
      proto_ev = 1'b0;
      romwr_ev = 1'b0;
      case (mode)
         DPM_SP:
         begin
            wr[0]    = req_w[0];
            rd[0]    = req_r[0] && !req_w[0];
            proto_ev = req_w[0] && req_r[0];
         end
         DPM_SDP:
         begin
            wr[0] = req_w[0];
            rd[1] = req_r[1];
         end
         DPM_TDP:
         begin
            wr = req_w;
            rd = req_r;
         end
         DPM_SHIFT:
         begin
            wr[0] = req_w[0];
            rd[0] = req_r[0];
         end
         DPM_ROM:
         begin
            rd       = req_r;
            romwr_ev = |req_w;
         end
         DPM_FIFO:
         begin
            fwr      = req_w[0] && !full;
            frd      = req_r[1] && !empty;
            proto_ev = req_w[0] && req_r[1] && empty;
            wr[0]    = fwr;
            rd[1]    = frd;
            wa[0]    = wptr_r;
            wa[1]    = rptr_r;
            ln[0]    = 2'b11;
         end
         default:
         begin
            wr = 2'b00;
         end
      endcase
      for (int p = 0; p < 2; p++)
      begin
         old[p] = mem[wa[p]];
         // own write seen at once except in shift mode; other port's write not seen
         if (wr[p] && (mode != DPM_SHIFT))
            rv[p] = merge(old[p], wd[p], ln[p]);
         else
            rv[p] = old[p];
         if (nar[p])
            rv[p] = {8'h00, in_r[p].addr[0] ? rv[p][15:8] : rv[p][7:0]};
      end
   end

   // storage; port b lands after port a on a shared word
   always_ff @(posedge aclk)
   begin
      if (init_we)
         mem[iaddr_r] <= merge(mem[iaddr_r], wdata_r[15:0], wstrb_r[1:0]);
      for (int p = 0; p < 2; p++)
      begin
         if (wr[p])
            mem[wa[p]] <= merge(old[p], wd[p], ln[p]);
      end
   end

   // memory read latch and output register, bypassable
   always_ff @(posedge aclk)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (!aresetn)
            rd_r[p] <= '0;
         else if (rd[p])
            rd_r[p] <= rv[p];
         if (!aresetn || (clr_ok && pin[p].clr_out))
            q_r[p] <= '0;
         else if (!ctrl_r[CTRL_OREG_POS + p])
         begin
            if (rd[p])
               q_r[p] <= rv[p];
         end
         else if (stb[2 + p])
            q_r[p] <= rd_r[p];
      end
   end

   assign dl_left_out  = q_r[0];
   assign dl_right_out = q_r[1];

   // fifo pointers and fill level
   assign empty = (cnt_r == 9'h000);
   assign full  = (cnt_r == 9'h100);
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !run || (mode != DPM_FIFO))
      begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end
      else
      begin
         if (fwr)
            wptr_r <= wptr_r + 8'h01;
         if (frd)
            rptr_r <= rptr_r + 8'h01;
         cnt_r <= cnt_r + {8'h00, fwr} - {8'h00, frd};
      end
   end

   // sticky error flags, set beats clear
   assign st_clr = wdo && (awaddr_r == DPM_STAT_OFS) && wstrb_r[0];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         proto_r <= 1'b0;
         romwr_r <= 1'b0;
      end
      else
      begin
         proto_r <= proto_ev || (proto_r && !(st_clr && wdata_r[ST_PROTO_POS]));
         romwr_r <= romwr_ev || (romwr_r && !(st_clr && wdata_r[ST_ROMWR_POS]));
      end
   end

   // write address and data, taken in either order
   assign wdo = aw_have_r && w_have_r && !bvalid_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= AXI_OKAY;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
      end
      else
      begin
         if (s_axi_awvalid && awready_r)
         begin
            aw_have_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
            awready_r <= 1'b0;
         end
         else if (!aw_have_r && !bvalid_r)
            awready_r <= 1'b1;
         if (s_axi_wvalid && wready_r)
         begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            wready_r <= 1'b0;
         end
         else if (!w_have_r && !bvalid_r)
            wready_r <= 1'b1;
         if (wdo)
         begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= hit(awaddr_r) ? AXI_OKAY : AXI_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   // control and init address registers
   assign init_we = wdo && (awaddr_r == DPM_IDATA_OFS) && !run;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r  <= DPM_CTRL_RST;
         iaddr_r <= '0;
      end
      else if (wdo && (awaddr_r == DPM_CTRL_OFS))
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wstrb_r[b])
               ctrl_r[8*b +: 8] <= wdata_r[8*b +: 8] & DPM_CTRL_MASK[8*b +: 8];
         end
      end
      else if (wdo && (awaddr_r == DPM_IADDR_OFS) && wstrb_r[0])
         iaddr_r <= wdata_r[7:0];
      else if (init_we)
         iaddr_r <= iaddr_r + 8'h01; // auto-step for loading
   end

   // status word
   always_comb
   begin
      stat                        = '0;
      stat[ST_CFGERR_POS]         = !cfg_ok;
      stat[ST_EMPTY_POS]          = empty;
      stat[ST_FULL_POS]           = full;
      stat[ST_PROTO_POS]          = proto_r;
      stat[ST_ROMWR_POS]          = romwr_r;
      stat[ST_CNT_POS +: 9]       = cnt_r;
   end

   // read channel, one beat at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= AXI_OKAY;
      end
      else if (s_axi_arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= hit({s_axi_araddr[7:2], 2'b00}) ? AXI_OKAY : AXI_SLVERR;
         case ({s_axi_araddr[7:2], 2'b00})
            DPM_CTRL_OFS:  rdata_r <= ctrl_r;
            DPM_STAT_OFS:  rdata_r <= stat;
            DPM_IADDR_OFS: rdata_r <= {24'h000000, iaddr_r};
            default:       rdata_r <= '0;
         endcase
      end
      else
      begin
         if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
         if (!rvalid_r && !arready_r)
            arready_r <= 1'b1;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
endmodule

// ==== tb/dpm_assertions.sv ====
// concurrent checks on the memory block ports
`timescale 1ns/1ps
module dpm_assertions
(
   input logic                  aclk,
   input logic                  aresetn,
   input logic [7:0]            s_axi_awaddr,
   input logic                  s_axi_awvalid,
   input logic                  s_axi_awready,
   input logic [31:0]           s_axi_wdata,
   input logic                  s_axi_wvalid,
   input logic                  s_axi_wready,
   input logic [1:0]            s_axi_bresp,
   input logic                  s_axi_bvalid,
   input logic                  s_axi_bready,
   input logic [7:0]            s_axi_araddr,
   input logic                  s_axi_arvalid,
   input logic                  s_axi_arready,
   input logic [31:0]           s_axi_rdata,
   input logic [1:0]            s_axi_rresp,
   input logic                  s_axi_rvalid,
   input logic                  s_axi_rready,
   input logic [1:0]            clk_stb,
   input dpm_pkg::dpm_port_type port_a,
   input logic [15:0]           dl_left_in,
   input logic [15:0]           dl_left_out
);
   import dpm_pkg::*;
   logic [7:0]  aw_r;
   logic [31:0] wd_r;
   logic [31:0] ctl_r;
   logic        run;
   // address and data of the write under way
   always_ff @(posedge aclk)
   begin
      if (s_axi_awvalid && s_axi_awready)
         aw_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
         wd_r <= s_axi_wdata;
   end
   // shadow of the control word, updated when its write completes
   always_ff @(posedge aclk)
      if (!aresetn)
         ctl_r <= DPM_CTRL_RST;
      else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == AXI_OKAY && aw_r[7:2] == 6'h0)
         ctl_r <= wd_r & DPM_CTRL_MASK;
   // enabled true dual-port with clears honoured
   assign run = ctl_r[CTRL_EN_POS] && ctl_r[2:0] == 3'd2 && ctl_r[4:3] != 2'd3;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both halves taken together: pair registered, response raised the edge after
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read response dropped");
   a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] != 4'h0
      |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
   a_ready_rise: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_wready
      && s_axi_arready) else $error("ready late after reset");
   a_same_port_new: assert property (run && !ctl_r[CTRL_OREG_POS] && !ctl_r[CTRL_NAR_POS]
      && clk_stb[0] && port_a.we && port_a.re && port_a.be == 2'b11 && !port_a.clr_in
      && !port_a.clr_out |-> ##2 dl_left_out == $past(dl_left_in, 2))
      else $error("same-port read during write not new data");
   a_clr_out_zero: assert property (run && port_a.clr_out |=> dl_left_out == 16'h0)
      else $error("output clear not seen");
   a_clr_in_keep: assert property (run && !ctl_r[CTRL_OREG_POS] && port_a.clr_in
      && !clk_stb[0] && !$past(clk_stb[0]) && !$past(clk_stb[0], 2)
      |=> $stable(dl_left_out) [*2]) else $error("input clear reached output");
endmodule
bind dpm_top dpm_assertions chk_u (.*);

// ==== tb/dpm_fabric.sv ====
// fabric-side user logic that drives both memory ports
`timescale 1ns/1ps
module dpm_fabric
(
   input  logic                  aclk,
   output logic [1:0]            clk_stb,
   output dpm_pkg::dpm_port_type port_a,
   output dpm_pkg::dpm_port_type port_b,
   output logic [15:0]           dl_left_in,
   output logic [15:0]           dl_right_in
);
   import dpm_pkg::*;
   logic busy;
   initial
   begin
      busy = 1'b0;
      clk_stb = 2'b00;
      port_a = '0;
      port_b = '0;
      dl_left_in = 16'h0;
      dl_right_in = 16'hffff;
   end
   // released link lines keep changing so stale data never looks valid
   always @(negedge aclk)
      if (!busy)
      begin
         dl_left_in  <= ~dl_left_in;
         dl_right_in <= dl_right_in ^ 16'h5a5a;
      end
   // one strobe per access; caller keeps read and write apart where needed
   task automatic access(input dpm_port_type pa, input dpm_port_type pb,
                         input logic [15:0] da, input logic [15:0] db, input logic s);
      @(posedge aclk);
      busy        <= 1'b1;
      clk_stb     <= {s, s};
      port_a      <= pa;
      port_b      <= pb;
      dl_left_in  <= da;
      dl_right_in <= db;
      @(posedge aclk);
      clk_stb <= 2'b00;
      port_a  <= '0;
      port_b  <= '0;
      busy    <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
endmodule

// ==== tb/dpm_top_tb.sv ====
// self-checking bench for the dual-port memory block
`timescale 1ns/1ps
module dpm_top_tb;
   import dpm_pkg::*;
   logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic         s_axi_rready, mem_rdy;
   logic [7:0]   s_axi_awaddr, s_axi_araddr;
   logic [8:0]   a;
   logic [31:0]  s_axi_wdata, s_axi_rdata, seed_r;
   logic [3:0]   s_axi_wstrb;
   logic [1:0]   s_axi_bresp, s_axi_rresp, clk_stb;
   dpm_port_type port_a, port_b;
   logic [15:0]  dl_left_in, dl_right_in, dl_left_out, dl_right_out, lo, ro, d1, d2, d3;
   logic [33:0]  exp_q[$], mem_q[$];
   int           failures, samples_checked;

   dpm_top dut_u (.*);
   dpm_fabric fabric_u (.*);

   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   function automatic logic [15:0] rnd();
      seed_r = {seed_r[30:0], seed_r[31] ^ seed_r[21] ^ seed_r[1] ^ seed_r[0]};
      return seed_r[15:0];
   endfunction
   function automatic dpm_port_type pt(input logic [8:0] ad, input logic [5:0] f);
      return {ad, f};
   endfunction
   task automatic check(input logic [33:0] g, input logic [33:0] e);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= ad;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      exp_q.push_back({er, 32'h0});
      fork
         begin
            do @(posedge aclk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      exp_q.push_back({er, d});
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // one port access, then note the expected link outputs
   task automatic mem(input dpm_port_type pa, input dpm_port_type pb, input logic [15:0] da,
                      input logic [15:0] db, input logic s, input logic [15:0] nl,
                      input logic [15:0] nr);
      fabric_u.access(pa, pb, da, db, s);
      lo = nl;
      ro = nr;
      mem_q.push_back({2'b00, nr, nl});
      mem_rdy <= 1'b1;
      @(posedge aclk);
      mem_rdy <= 1'b0;
   endtask
   task test_done;
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // compares each completed answer with the oldest note
   always @(posedge aclk)
      if (s_axi_bvalid && s_axi_bready)
         check({s_axi_bresp, 32'h0}, exp_q.pop_front());
      else if (s_axi_rvalid && s_axi_rready)
         check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      else if (mem_rdy)
         check({2'b00, dl_right_out, dl_left_out}, mem_q.pop_front());

   // watchdog against a hung handshake
   initial
   begin
      repeat (6000) @(posedge aclk);
      failures++;
      test_done;
   end

   initial
   begin
      aresetn = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 8'h0;
      s_axi_araddr = 8'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      failures = 0;
      samples_checked = 0;
      mem_rdy = 1'b0;
      seed_r = 32'hbb0f62db;
      lo = 16'h0;
      ro = 16'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_rd(DPM_CTRL_OFS, DPM_CTRL_RST, AXI_OKAY);
      axi_rd(8'h10, 32'h0, AXI_SLVERR);
      axi_wr(8'h14, 32'hffff_ffff, AXI_SLVERR);
      // single-port with independent clocks is refused
      axi_wr(DPM_CTRL_OFS, 32'h0000_0600, AXI_OKAY);
      axi_rd(DPM_STAT_OFS, 32'h0000_0003, AXI_OKAY);
      // rom words loaded while disabled; writes later ignored
      d1 = rnd();
      d2 = rnd();
      axi_wr(DPM_CTRL_OFS, 32'h0000_040c, AXI_OKAY);
      axi_wr(DPM_IADDR_OFS, 32'h0000_0005, AXI_OKAY);
      axi_wr(DPM_IDATA_OFS, {16'h0, d1}, AXI_OKAY);
      axi_wr(DPM_IDATA_OFS, {16'h0, d2}, AXI_OKAY);
      axi_wr(DPM_CTRL_OFS, 32'h0000_060c, AXI_OKAY);
      mem(pt(9'h5, 6'b111000), '0, ~d1, 16'h0, 1'b1, lo, ro);
      mem(pt(9'h5, 6'b000100), '0, 16'h0, 16'h0, 1'b1, d1, ro);
      mem(pt(9'h6, 6'b000100), '0, 16'h0, 16'h0, 1'b1, d2, ro);
      axi_rd(DPM_STAT_OFS, 32'h0000_0012, AXI_OKAY);
      axi_wr(DPM_STAT_OFS, 32'h0000_0010, AXI_OKAY);
      axi_rd(DPM_STAT_OFS, 32'h0000_0002, AXI_OKAY);
      // true dual-port, random words
      axi_wr(DPM_CTRL_OFS, 32'h0000_060a, AXI_OKAY);
      for (int i = 0; i < 3; i++)
      begin
         d1 = rnd();
         a = {1'b0, d1[7:0]};
         d1 = rnd();
         d2 = rnd();
         d3 = rnd();
         mem(pt(a, 6'b111000), '0, d1, 16'h0, 1'b1, lo, ro);
         mem(pt(a, 6'b111100), pt(a, 6'b000100), d2, 16'h0, 1'b1, d2, d1);
         mem(pt(a, 6'b011100), pt(a, 6'b000100), d3, 16'h0, 1'b1, {d2[15:8], d3[7:0]}, d2);
         mem(pt(a, 6'b000100), pt(a + 9'h1, 6'b111100), 16'h0, d1, 1'b1, lo, d1);
      end
      // byte-wide port A against word-wide port B
      axi_wr(DPM_CTRL_OFS, 32'h0000_068a, AXI_OKAY);
      mem(pt({a[7:0], 1'b1}, 6'b011000), '0, d1, 16'h0, 1'b1, lo, ro);
      mem('0, pt(a, 6'b000100), 16'h0, 16'h0, 1'b1, lo, {d1[7:0], d3[7:0]});
      // clears without a strobe
      mem(pt(9'h0, 6'b000010), '0, 16'h0, 16'h0, 1'b0, lo, ro);
      mem(pt(9'h0, 6'b000001), '0, 16'h0, 16'h0, 1'b0, 16'h0, ro);
      // single-port read with write drops the read
      axi_wr(DPM_CTRL_OFS, 32'h0000_0608, AXI_OKAY);
      mem(pt(a, 6'b111100), '0, d2, 16'h0, 1'b1, lo, ro);
      axi_rd(DPM_STAT_OFS, 32'h0000_000a, AXI_OKAY);
      // fifo: port a pushes one word, port b pops it back
      axi_wr(DPM_CTRL_OFS, 32'h0000_060d, AXI_OKAY);
      mem(pt(9'h0, 6'b111000), '0, d3, 16'h0, 1'b1, lo, ro);
      mem('0, pt(9'h0, 6'b000100), 16'h0, 16'h0, 1'b1, lo, d3);
      axi_rd(DPM_STAT_OFS, 32'h0000_000a, AXI_OKAY);
      test_done;
   end
endmodule
